//--- rtl/link_error_log_defs.svh
// Offsets, field positions, reset values and timing counts of the link error log
`ifndef LINK_ERROR_LOG_DEFS_SVH
`define LINK_ERROR_LOG_DEFS_SVH
// Byte addresses on the register bus
`define LEL_ERR_REG_OFFSET     20'h41000
`define LEL_PORT_REG_OFFSET    20'h41004
`define LEL_IRQ_STAT_OFFSET    20'h41008
`define LEL_IRQ_MASK_OFFSET    20'h4100C
// Error register bit positions, and the port register heartbeat select bit
`define LEL_BIT_VPE_NEW        24
`define LEL_BIT_VPE_OLD        23
`define LEL_BIT_RX_TBL_PAR     21
`define LEL_BIT_ACK_DROP       20
`define LEL_BIT_CMD_FRAME      19
`define LEL_BIT_FATAL          18
`define LEL_BIT_HB_EN          17
`define LEL_BIT_CHK_DIS        16
`define LEL_BIT_HB_SEL         26
// Reset value of every register
`define LEL_RESET_VALUE        32'h0000_0000
// Clock and heartbeat periods
`define LEL_CLK_HZ             40000000
`define LEL_HB_LONG_S          8
`define LEL_HB_SHORT_S         2
`define LEL_HB_LONG_CYC        (`LEL_HB_LONG_S * `LEL_CLK_HZ)
`define LEL_HB_SHORT_CYC       (`LEL_HB_SHORT_S * `LEL_CLK_HZ)
// Interrupt event bit positions
`define LEL_EV_VPE             0
`define LEL_EV_TBL             1
`define LEL_EV_ACK             2
`define LEL_EV_FRAME           3
`define LEL_EV_HB              4
`define LEL_EV_W               5
`endif

//--- rtl/link_error_log_pkg.sv
// Types shared by the link error log block
package link_error_log_pkg;
  // Link-side event strobes, one cycle each
  typedef struct packed {
    logic vert_par;     // Vertical parity error on a received packet
    logic horiz_par;    // Horizontal parity error on the same packet
    logic tbl_par_rx;   // Bad parity reading table entry for a link write
    logic tbl_direct;   // Table read is a direct software read
    logic ack_drop;     // Acknowledge response dropped
    logic cmd_mismatch; // Redundant command copies disagree
    logic tx_issue;     // This node issued a transmit transaction
  } link_event_t;
  // Heartbeat supervisor states
  typedef enum logic [1:0] {
    HB_IDLE  = 2'h0,
    HB_COUNT = 2'h1,
    HB_FATAL = 2'h2
  } hb_state_t;
endpackage

//--- rtl/link_error_log_low_half.sv
// Lower half of the link error register with heartbeat supervisor and Avalon slave
//
// What this block does
// - Vertical-only parity error sets flag, receive indication
// - Later revision reports vertical parity in bit 24
// - Receive table parity error sets flag, indication
// - Table parity error forwards write, byte enables off
// - No table parity check on direct reads
// - Dropped acknowledge recorded as clearable status bit
// - Command copy mismatch sets flag, forces fatal
// - Heartbeat enforcement takes port offline on silence
// - Heartbeat period selected by port register bit 26
// - Checking-disable bit suppresses all link parity reporting
// - Heartbeat is 8 s when selected, else 2 s
// - Heartbeat timeout sets flag, indications, fatal, link-ok low
`include "link_error_log_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module link_error_log_low_half #(
  parameter logic [31:0] HB_LONG_CYC  = `LEL_HB_LONG_CYC,
  parameter logic [31:0] HB_SHORT_CYC = `LEL_HB_SHORT_CYC,
  parameter bit          LATER_REV    = 1'b0
) (
  // Clock, reset, enable
  input  wire logic                         sys_clk,
  input  wire logic                         rstn,
  input  wire logic                         clk_en,
  // Avalon-MM slave
  input  wire logic [19:0]                  avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  // Link-side events
  input  wire link_error_log_pkg::link_event_t link_ev,
  input  wire logic                         fwd_valid,
  input  wire logic [3:0]                   fwd_byte_en_in,
  output logic      [3:0]                   fwd_byte_en_out,
  // Error state outputs
  output logic                              receive_parity_error_indication,
  output logic                              transmit_parity_error_indication,
  output logic                              fatal_state,
  output logic                              link_ok,
  output logic                              port_offline,
  output logic                              heartbeat_timeout,
  output logic                              irq
);
  // Register state
  logic [31:0] err_ff,  nxt_err;        // Error register image
  logic [31:0] port_ff, nxt_port;       // Port control register (only bit 26 used)
  logic [`LEL_EV_W-1:0] ist_ff, nxt_ist; // Interrupt status
  logic [`LEL_EV_W-1:0] imk_ff, nxt_imk; // Interrupt mask
  logic [31:0] rd_ff,   nxt_rd;         // Read data
  logic        ack_ff,  nxt_ack;        // Answer phase flag
  logic        rpe_ff,  nxt_rpe;        // Receive parity indication
  logic        tpe_ff,  nxt_tpe;        // Transmit parity indication
  logic        fatal_ff, nxt_fatal;     // Fatal link state
  logic        poison_ff, nxt_poison;   // Mask byte enables of the pending write
  logic [3:0]  fbe_ff,  nxt_fbe;        // Forwarded byte enables
  logic [31:0] hb_cnt_ff, nxt_hb_cnt;   // Heartbeat counter
  link_error_log_pkg::hb_state_t hb_ff, nxt_hb; // Heartbeat state
  // Decoded strobes and events
  logic        wr_acc, rd_acc;
  logic [31:0] wmask;
  logic        chk_on, ev_vpe, ev_tbl, ev_frame, ev_hb;
  logic [31:0] hb_limit;
  logic [31:0] w1c;

  // Byte lanes expanded to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  // Write accepted on the answer cycle; read data loaded in the wait cycle so it stands at the answer edge
  assign wr_acc = avs_write & ack_ff;
  assign rd_acc = avs_read & ~ack_ff;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata = rd_ff;

  // Link-side event qualification
  always_comb begin
    chk_on   = ~err_ff[`LEL_BIT_CHK_DIS];
    ev_vpe   = chk_on & link_ev.vert_par & ~link_ev.horiz_par;
    ev_tbl   = chk_on & link_ev.tbl_par_rx & ~link_ev.tbl_direct;
    ev_frame = link_ev.cmd_mismatch;
    hb_limit = port_ff[`LEL_BIT_HB_SEL] ? HB_LONG_CYC : HB_SHORT_CYC;
  end

  // Heartbeat supervisor next state
  always_comb begin
    nxt_hb     = hb_ff;
    nxt_hb_cnt = hb_cnt_ff;
    ev_hb      = 1'b0;
    case (hb_ff)
      link_error_log_pkg::HB_IDLE: begin
        nxt_hb_cnt = 32'h0000_0000;
        if (err_ff[`LEL_BIT_HB_EN]) begin
          nxt_hb = link_error_log_pkg::HB_COUNT;
        end
      end
      link_error_log_pkg::HB_COUNT: begin
        if (!err_ff[`LEL_BIT_HB_EN]) begin
          nxt_hb = link_error_log_pkg::HB_IDLE;
        end else if (link_ev.tx_issue) begin
          nxt_hb_cnt = 32'h0000_0000;
        end else if (hb_cnt_ff >= hb_limit - 32'h0000_0001) begin
          ev_hb  = 1'b1;
          nxt_hb = link_error_log_pkg::HB_FATAL;
        end else begin
          nxt_hb_cnt = hb_cnt_ff + 32'h0000_0001;
        end
      end
      link_error_log_pkg::HB_FATAL: begin
        // Port stays offline until the fatal flag is cleared by software
        if (!fatal_ff) begin
          nxt_hb = link_error_log_pkg::HB_IDLE;
        end
      end
      default: nxt_hb = link_error_log_pkg::HB_IDLE;
    endcase
  end

  // Register file and error logging next state
  always_comb begin
    nxt_err    = err_ff;
    nxt_port   = port_ff;
    nxt_ist    = ist_ff;
    nxt_imk    = imk_ff;
    nxt_rd     = rd_ff;
    nxt_ack    = (avs_read | avs_write) & ~ack_ff;
    nxt_rpe    = rpe_ff;
    nxt_tpe    = tpe_ff;
    nxt_fatal  = fatal_ff;
    w1c        = (wr_acc && avs_address == `LEL_ERR_REG_OFFSET) ? (avs_writedata & wmask) : 32'h0000_0000;
    // Software writes: clears first, so hardware sets below win
    if (wr_acc) begin
      case (avs_address)
        `LEL_ERR_REG_OFFSET: begin
          nxt_err = err_ff & ~w1c;
          nxt_err[`LEL_BIT_HB_EN]  = (avs_writedata[`LEL_BIT_HB_EN] & wmask[`LEL_BIT_HB_EN]) |
                                     (err_ff[`LEL_BIT_HB_EN] & ~wmask[`LEL_BIT_HB_EN]);
          nxt_err[`LEL_BIT_CHK_DIS] = (avs_writedata[`LEL_BIT_CHK_DIS] & wmask[`LEL_BIT_CHK_DIS]) |
                                      (err_ff[`LEL_BIT_CHK_DIS] & ~wmask[`LEL_BIT_CHK_DIS]);
          if (w1c[`LEL_BIT_FATAL]) begin
            nxt_fatal = 1'b0;                                                  // Clearing fatal leaves the state
            nxt_rpe   = 1'b0;
            nxt_tpe   = 1'b0;
          end
        end
        `LEL_PORT_REG_OFFSET: nxt_port = (avs_writedata & wmask) | (port_ff & ~wmask);
        `LEL_IRQ_STAT_OFFSET: nxt_ist  = ist_ff & ~avs_writedata[`LEL_EV_W-1:0];
        `LEL_IRQ_MASK_OFFSET: nxt_imk  = avs_writedata[`LEL_EV_W-1:0];
        default: ;                                                             // Unmapped writes ignored
      endcase
    end
    // Hardware sets
    if (ev_vpe) begin
      if (LATER_REV) nxt_err[`LEL_BIT_VPE_NEW] = 1'b1;
      else           nxt_err[`LEL_BIT_VPE_OLD] = 1'b1;
      nxt_rpe = 1'b1;
    end
    if (ev_tbl) begin
      nxt_err[`LEL_BIT_RX_TBL_PAR] = 1'b1;
      nxt_rpe = 1'b1;
    end
    if (link_ev.ack_drop) nxt_err[`LEL_BIT_ACK_DROP] = 1'b1;
    if (ev_frame) begin
      nxt_err[`LEL_BIT_CMD_FRAME] = 1'b1;
      nxt_fatal = 1'b1;
    end
    if (ev_hb) begin
      nxt_rpe = 1'b1;
      nxt_tpe = 1'b1;
      nxt_fatal = 1'b1;
    end
    if (nxt_fatal & ~fatal_ff) nxt_err[`LEL_BIT_FATAL] = 1'b1;
    // Only the implemented lower-half bits are kept
    nxt_err = nxt_err & 32'h01BF_0000;
    if (!LATER_REV) nxt_err[`LEL_BIT_VPE_NEW] = 1'b0;
    else            nxt_err[`LEL_BIT_VPE_OLD] = 1'b0;
    // Interrupt status, set wins over clear
    nxt_ist = nxt_ist | {ev_hb, ev_frame, link_ev.ack_drop, ev_tbl, ev_vpe};
    // Read data mux
    if (rd_acc) begin
      case (avs_address)
        `LEL_ERR_REG_OFFSET:  nxt_rd = err_ff;
        `LEL_PORT_REG_OFFSET: nxt_rd = port_ff;
        `LEL_IRQ_STAT_OFFSET: nxt_rd = {27'h0, ist_ff};
        `LEL_IRQ_MASK_OFFSET: nxt_rd = {27'h0, imk_ff};
        default:              nxt_rd = 32'h0000_0000;                          // Unmapped reads zero
      endcase
    end
  end

  // Byte enables of forwarded writes
  always_comb begin
    nxt_poison = poison_ff;
    nxt_fbe    = fbe_ff;
    if (ev_tbl) nxt_poison = 1'b1;
    if (fwd_valid) begin
      nxt_fbe = (ev_tbl | poison_ff) ? 4'h0 : fwd_byte_en_in;
      if (!ev_tbl) nxt_poison = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      err_ff    <= `LEL_RESET_VALUE;
      port_ff   <= `LEL_RESET_VALUE;
      ist_ff    <= '0;
      imk_ff    <= '0;
      rd_ff     <= 32'h0000_0000;
      ack_ff    <= 1'b0;
      rpe_ff    <= 1'b0;
      tpe_ff    <= 1'b0;
      fatal_ff  <= 1'b0;
      poison_ff <= 1'b0;
      fbe_ff    <= 4'h0;
      hb_cnt_ff <= 32'h0000_0000;
      hb_ff     <= link_error_log_pkg::HB_IDLE;
    end else if (clk_en) begin
      err_ff    <= nxt_err;
      port_ff   <= nxt_port & 32'h0400_0000;
      ist_ff    <= nxt_ist;
      imk_ff    <= nxt_imk;
      rd_ff     <= nxt_rd;
      ack_ff    <= nxt_ack;
      rpe_ff    <= nxt_rpe;
      tpe_ff    <= nxt_tpe;
      fatal_ff  <= nxt_fatal;
      poison_ff <= nxt_poison;
      fbe_ff    <= nxt_fbe;
      hb_cnt_ff <= nxt_hb_cnt;
      hb_ff     <= nxt_hb;
    end
  end

  // Outputs
  assign receive_parity_error_indication  = rpe_ff;
  assign transmit_parity_error_indication = tpe_ff;
  assign fatal_state      = fatal_ff;
  assign link_ok          = ~fatal_ff;
  assign port_offline     = fatal_ff;
  assign heartbeat_timeout = (hb_ff == link_error_log_pkg::HB_FATAL);
  assign fwd_byte_en_out  = fbe_ff;
  assign irq              = |(ist_ff & imk_ff);
endmodule
`default_nettype wire

//--- bench/link_error_log_chk.sv
// Port-level property checks for the link error log
`include "link_error_log_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module link_error_log_chk #(
  parameter logic [31:0] HB_LONG_CYC  = 32'h28,
  parameter logic [31:0] HB_SHORT_CYC = 32'hA
) (
  // Clock, reset and register bus
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [19:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Link side and error state
  input wire link_error_log_pkg::link_event_t link_ev,
  input wire logic        fwd_valid,
  input wire logic [3:0]  fwd_byte_en_out,
  input wire logic        receive_parity_error_indication,
  input wire logic        transmit_parity_error_indication,
  input wire logic        fatal_state,
  input wire logic        link_ok,
  input wire logic        port_offline,
  input wire logic        heartbeat_timeout
);
  logic        dis_ff, en_ff, sel_ff;    // Shadows of check-off, enforce, select
  logic        nxt_dis, nxt_en, nxt_sel; // Their next values
  logic [31:0] sil_ff, nxt_sil, lim;     // Silent cycles and active limit
  logic        acc;                      // Write accepted this edge
  assign acc = avs_write && !avs_waitrequest;
  assign lim = sel_ff ? HB_LONG_CYC : HB_SHORT_CYC;
  // Follow accepted writes and count cycles with no transmit
  always_comb begin
    {nxt_dis, nxt_en, nxt_sel} = {dis_ff, en_ff, sel_ff};
    if (acc && avs_address == `LEL_ERR_REG_OFFSET) begin
      {nxt_en, nxt_dis} = avs_writedata[17:16];
    end
    if (acc && avs_address == `LEL_PORT_REG_OFFSET) begin
      nxt_sel = avs_writedata[26];
    end
    nxt_sil = (link_ev.tx_issue || !en_ff) ? 32'h0 : sil_ff + 32'h1;
  end
  // Register the helpers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {dis_ff, en_ff, sel_ff, sil_ff} <= '0;
    end else begin
      {dis_ff, en_ff, sel_ff, sil_ff} <= {nxt_dis, nxt_en, nxt_sel, nxt_sil};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  AST_ONE_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait state");
  AST_VERT_RPE: assert property (link_ev.vert_par && !link_ev.horiz_par && !dis_ff |=>
    receive_parity_error_indication) else $error("vertical parity not indicated");
  AST_TBL_RPE: assert property (link_ev.tbl_par_rx && !link_ev.tbl_direct && !dis_ff |=>
    receive_parity_error_indication) else $error("table parity not indicated");
  AST_POISON: assert property (fwd_valid && link_ev.tbl_par_rx && !link_ev.tbl_direct && !dis_ff |=>
    fwd_byte_en_out == 4'h0) else $error("byte enables not cleared");
  AST_FRAME: assert property (link_ev.cmd_mismatch |=> fatal_state && !link_ok)
    else $error("framing error did not force fatal");
  AST_HB_FIRE: assert property (en_ff && sil_ff == lim + 32'h2 |-> heartbeat_timeout)
    else $error("heartbeat timeout missed");
  AST_HB_QUIET: assert property ($rose(heartbeat_timeout) |-> en_ff && sil_ff >= lim - 32'h2)
    else $error("heartbeat timeout too early");
  AST_HB_STATE: assert property ($rose(heartbeat_timeout) |-> ##[0:1] (fatal_state && port_offline
    && transmit_parity_error_indication && receive_parity_error_indication)) else $error("timeout state wrong");
  AST_RSVD_ZERO: assert property (avs_read && !avs_waitrequest && avs_address == `LEL_ERR_REG_OFFSET
    |-> avs_readdata[15:0] == 16'h0 && !avs_readdata[22]) else $error("reserved bits not zero");
endmodule
bind link_error_log_low_half link_error_log_chk #(.HB_LONG_CYC(HB_LONG_CYC), .HB_SHORT_CYC(HB_SHORT_CYC)) chk (
  .sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .link_ev, .fwd_valid, .fwd_byte_en_out, .receive_parity_error_indication, .transmit_parity_error_indication,
  .fatal_state, .link_ok, .port_offline, .heartbeat_timeout);
`default_nettype wire

//--- bench/link_far_end.sv
// Peer adapter model: event pulses, forwarded data cycles and heartbeats
`timescale 1ns/1ps
`default_nettype none
module link_far_end (
  // Commands from the bench
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [6:0] ev,
  input  wire logic       fv,
  input  wire logic [3:0] be,
  input  wire logic [7:0] gap,
  // Toward the block
  output var link_error_log_pkg::link_event_t link_ev,
  output logic            fwd_valid,
  output logic [3:0]      fwd_byte_en_in
);
  logic [7:0] cnt_ff = 8'h0; // Cycles since the last transmit
  logic       hb;            // Transmit due now
  assign hb = gap != 8'h0 && cnt_ff >= gap - 8'h1;
  initial link_ev = '0;
  initial fwd_valid = 1'b0;
  initial fwd_byte_en_in = 4'h0;
  // Peer without a hub sends traffic every gap cycles; idle enables toggle
  always @(posedge sys_clk) begin
    cnt_ff <= hb ? 8'h0 : cnt_ff + 8'h1;
    link_ev <= (go ? ev : 7'h0) | {6'h0, hb};
    fwd_valid <= go && fv;
    fwd_byte_en_in <= (go && fv) ? be : ~fwd_byte_en_in;
  end
endmodule
`default_nettype wire

//--- bench/link_error_log_low_half_tb_top.sv
// Self-checking bench for the link error log
`include "link_error_log_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module link_error_log_low_half_tb_top;
  localparam logic [19:0] EA = `LEL_ERR_REG_OFFSET;
  localparam logic [19:0] PA = `LEL_PORT_REG_OFFSET;
  localparam logic [19:0] SA = `LEL_IRQ_STAT_OFFSET;
  localparam logic [19:0] MA = `LEL_IRQ_MASK_OFFSET;
  logic        sys_clk = 1'b0, rstn = 1'b0, go = 1'b0, fv = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [19:0] avs_address = 20'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, got, q, r;
  logic [6:0]  ev = 7'h0;
  logic [3:0]  be = 4'h0, bo, fwd_byte_en_in, fwd_byte_en_out;
  logic [7:0]  gap = 8'h0;
  logic        avs_waitrequest, fwd_valid, receive_parity_error_indication, transmit_parity_error_indication;
  logic        fatal_state, link_ok, port_offline, heartbeat_timeout, irq;
  link_error_log_pkg::link_event_t link_ev;
  logic [31:0] exp_q[$];
  int          errors = 0, n_tests = 0;
  event        res_e;
  wire  [6:0]  st = {irq, heartbeat_timeout, port_offline, link_ok, fatal_state,
                     transmit_parity_error_indication, receive_parity_error_indication};
  always #12.5 sys_clk = ~sys_clk;
  link_error_log_low_half #(.HB_LONG_CYC(32'h28), .HB_SHORT_CYC(32'hA), .LATER_REV(1'b0)) uut (
    .sys_clk, .rstn, .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .link_ev, .fwd_valid, .fwd_byte_en_in,
    .fwd_byte_en_out, .receive_parity_error_indication, .transmit_parity_error_indication,
    .fatal_state, .link_ok, .port_offline, .heartbeat_timeout, .irq);
  link_far_end far (.sys_clk, .go, .ev, .fv, .be, .gap, .link_ev, .fwd_valid, .fwd_byte_en_in);
  // Monitor: take the oldest expectation and compare
  always @(res_e) begin
    n_tests++;
    if (got !== exp_q[0]) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp_q[0], got);
    end
    exp_q.pop_front();
  end
  task automatic note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    got = g;
    ->res_e;
    @(posedge sys_clk);
  endtask
  // One bus access; waits for the answer, read data kept in q
  task automatic bus(input bit w, input logic [19:0] a, input logic [31:0] d);
    int k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Hold the request until waitrequest is sampled low at a rising edge
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (avs_waitrequest !== 1'b0) begin
      errors++;
      stop_test();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    note(e, q);
  endtask
  task automatic chk_st(input logic [6:0] m, input logic [6:0] e);
    @(negedge sys_clk);
    note(32'(e), 32'(st & m));
  endtask
  // Ask the peer for one event cycle, optionally with a data cycle
  task automatic pulse(input logic [6:0] e, input bit v);
    r = $urandom;
    ev <= e;
    fv <= v;
    be <= r[3:0];
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    bo = fwd_byte_en_out;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic reset();
    rstn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
  // Main sequence
  initial begin
    r = $urandom(32'h0a427083);
    reset();
    rd(EA, 32'h0);
    chk_st(7'h7F, 7'h08);
    pulse(7'h60, 1'b0);
    rd(EA, 32'h0);
    pulse(7'h40, 1'b0);
    rd(EA, 32'h0080_0000);
    chk_st(7'h01, 7'h01);
    bus(1'b1, EA, 32'h0);
    rd(EA, 32'h0080_0000);
    bus(1'b1, EA, 32'h0080_0000);
    rd(EA, 32'h0);
    pulse(7'h00, 1'b1);
    note(32'(be), 32'(bo));
    pulse(7'h18, 1'b1);
    note(32'(be), 32'(bo));
    rd(EA, 32'h0);
    pulse(7'h10, 1'b1);
    note(32'h0, 32'(bo));
    pulse(7'h00, 1'b1);
    note(32'h0, 32'(bo));
    rd(EA, 32'h0020_0000);
    pulse(7'h04, 1'b0);
    rd(EA, 32'h0030_0000);
    chk_st(7'h0C, 7'h08);
    pulse(7'h02, 1'b0);
    rd(EA, 32'h003C_0000);
    chk_st(7'h0C, 7'h04);
    bus(1'b1, EA, 32'h003C_0000);
    rd(EA, 32'h0);
    chk_st(7'h0F, 7'h08);
    rd(SA, 32'h0000_000F);
    chk_st(7'h40, 7'h00);
    bus(1'b1, MA, 32'h0000_001F);
    chk_st(7'h40, 7'h40);
    bus(1'b1, SA, 32'h0000_000F);
    rd(SA, 32'h0);
    chk_st(7'h40, 7'h00);
    bus(1'b1, EA, 32'h0001_0000);
    pulse(7'h40, 1'b0);
    pulse(7'h10, 1'b1);
    note(32'(be), 32'(bo));
    rd(EA, 32'h0001_0000);
    chk_st(7'h03, 7'h00);
    r = $urandom;
    bus(1'b1, 20'h41010, r);
    rd(20'h41010, 32'h0);
    // Heartbeat with each period: traffic just in time, then too sparse for the short period and none for the long one
    for (int i = 0; i < 2; i++) begin
      reset();
      bus(1'b1, PA, i ? 32'h0400_0000 : 32'h0);
      rd(PA, i ? 32'h0400_0000 : 32'h0);
      gap <= i ? 8'h1E : 8'h08;
      bus(1'b1, EA, 32'h0002_0000);
      repeat (100) @(posedge sys_clk);
      chk_st(7'h3F, 7'h08);
      gap <= i ? 8'h00 : 8'h0F;
      repeat (60) @(posedge sys_clk);
      chk_st(7'h3F, 7'h37);
      rd(EA, 32'h0006_0000);
    end
    stop_test();
  end
endmodule
`default_nettype wire
